// [audio_clk_defines.svh]
// offsets, field positions, reset values and divider constants
`ifndef AUDIO_CLK_DEFINES_SVH
`define AUDIO_CLK_DEFINES_SVH

// ****************************************************************
// register byte offsets
// ****************************************************************
`define ACD_OFF_CTRL    8'h00
`define ACD_OFF_PDMDIV  8'h04
`define ACD_OFF_PCM0    8'h08
`define ACD_OFF_PCM1    8'h0C
`define ACD_OFF_I2STX   8'h10
`define ACD_OFF_STATUS  8'h14

// ****************************************************************
// field positions
// ****************************************************************
`define ACD_CTRL_EXT_BIT   1
`define ACD_CTRL_FAM_BIT   2
`define ACD_CTRL_RATE_LSB  4
`define ACD_CTRL_WLEN_LSB  6

// ****************************************************************
// reset values
// ****************************************************************
`define ACD_CTRL_RST   8'h00
`define ACD_DIV1_RST   3'h1
`define ACD_DIV2_RST   3'h1
`define ACD_DIV3_RST   5'h02
`define ACD_DEC_RST    8'h40

// ****************************************************************
// divisor limits
// ****************************************************************
`define ACD_DIV12_MIN  3'h1
`define ACD_DIV12_MAX  3'h4
`define ACD_DIV3_MIN   5'h02
`define ACD_DIV3_MAX   5'h10

// ****************************************************************
// audio pll settings per sample family
// ****************************************************************
`define ACD_PLL_P_441  8'h15
`define ACD_PLL_Q_441  8'h10
`define ACD_PLL_P_48   8'h0A
`define ACD_PLL_Q_48   8'h07

// ****************************************************************
// codec clock dividers, base rate, for 8, 16, 32 bit words
// ****************************************************************
`define ACD_CDIV_W8    6'h20
`define ACD_CDIV_W16   6'h10
`define ACD_CDIV_W32   6'h08

`endif

// [audio_clk_pkg.sv]
// types shared by the audio clock divider chain
`default_nettype none
package audio_clk_pkg;
  // sample rate band of the i2s word clock
  typedef enum logic [1:0] {RATE_BASE, RATE_96, RATE_192} rate_t;
  // i2s word length choice
  typedef enum logic [1:0] {WLEN_8, WLEN_16, WLEN_32} wlen_t;
  // control register image
  typedef struct packed {
    wlen_t wlen;
    rate_t rate;
    logic rsvd;
    logic fam48;
    logic ext_mclk;
    logic enable;
  } ctrl_t;
  // divisor register image for the microphone chain
  typedef struct packed {
    logic [7:0] dec;
    logic [2:0] rsvd;
    logic [4:0] div3;
    logic [1:0] rsvd2;
    logic [2:0] div2;
    logic [2:0] div1;
  } pdm_div_t;
endpackage
`default_nettype wire

// [audio_clock_divider_chain.sv]
// audio clock divider chain with pdm decimators and i2s master
//
// Chosen here: the address map and the Wishbone interface to the registers.
`include "audio_clk_defines.svh"
`default_nettype none

// Operation
// - converter tick divides root clock by one to four
// - master tick divides converter tick by one to four
// - microphone clock divides master tick by two to sixteen
// - sample rate is mic clock over twice decimation
// - two pdm channels give 16 to 24 bit words
// - i2s master makes word clock, 8-32 bit words
// - i2s master clock may come from external pin
// - base rate codec dividers 32, 16, 8 by word
// - 96k uses 16,8,4; 192k uses 8,4,2
// - 44.1k family pll multiply 21 divide 16
// - 48k family pll multiply 10 divide 7
module audio_clock_divider_chain #(
  parameter int PCM_W = 24
) (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  input wire logic PDM_DATA,
  input wire logic EXT_MCLK,
  output logic CONVERTER_CLOCK_TICK,
  output logic MASTER_CLOCK_TICK,
  output logic MIC_CLOCK_OUT,
  output logic PCM_VALID,
  output logic I2S_BCLK,
  output logic I2S_WS,
  output logic I2S_SDO,
  output logic [7:0] PLL_MULT,
  output logic [7:0] PLL_DIV
);

  // ****************************************************************
  // helper functions
  // ****************************************************************
  // keep a divisor in its legal window so a bad write cannot stall
  function automatic logic [4:0] clamp5(input logic [4:0] v,
      input logic [4:0] lo, input logic [4:0] hi);
    clamp5 = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  // ****************************************************************
  // wishbone slave
  // ****************************************************************
  audio_clk_pkg::ctrl_t ctrl_q; // control register
  audio_clk_pkg::pdm_div_t pdiv_q; // divisor register
  logic [31:0] tx_q; // next i2s word
  logic ack_q; // single cycle acknowledge
  logic [31:0] rdat_q; // registered read data
  logic [PCM_W-1:0] pcm0_q, pcm1_q; // latest pcm words
  logic [5:0] cdiv_q; // active codec divider
  wire req = WB_CYC_I & WB_STB_I & ~ack_q;
  wire wr = req & WB_WE_I;
  wire [31:0] wmask = {{8{WB_SEL_I[3]}}, {8{WB_SEL_I[2]}},
                       {8{WB_SEL_I[1]}}, {8{WB_SEL_I[0]}}};
  wire [31:0] pcm0_ext = 32'(signed'(pcm0_q));
  wire [31:0] pcm1_ext = 32'(signed'(pcm1_q));
  wire [31:0] rd_mux =
    (WB_ADR_I == `ACD_OFF_CTRL)   ? {24'h0, ctrl_q} :
    (WB_ADR_I == `ACD_OFF_PDMDIV) ? {8'h0, pdiv_q} :
    (WB_ADR_I == `ACD_OFF_PCM0)   ? pcm0_ext :
    (WB_ADR_I == `ACD_OFF_PCM1)   ? pcm1_ext :
    (WB_ADR_I == `ACD_OFF_I2STX)  ? tx_q :
    (WB_ADR_I == `ACD_OFF_STATUS) ?
      {10'h0, cdiv_q, PLL_DIV, PLL_MULT} : 32'h0;
  wire [31:0] ctrl_w = ({24'h0, ctrl_q} & ~wmask) | (WB_DAT_I & wmask);
  wire [31:0] pdiv_w = ({8'h0, pdiv_q} & ~wmask) | (WB_DAT_I & wmask);
  wire [31:0] tx_w = (tx_q & ~wmask) | (WB_DAT_I & wmask);

  // register writes; unmapped addresses ack and read zero
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ctrl_q <= audio_clk_pkg::ctrl_t'(`ACD_CTRL_RST);
      pdiv_q <= '{dec: `ACD_DEC_RST, rsvd: 3'h0, div3: `ACD_DIV3_RST,
                  rsvd2: 2'h0, div2: `ACD_DIV2_RST, div1: `ACD_DIV1_RST};
      tx_q <= 32'h0;
      ack_q <= 1'b0;
      rdat_q <= 32'h0;
    end else begin
      ack_q <= req;
      rdat_q <= req ? rd_mux : 32'h0;
      if (wr && WB_ADR_I == `ACD_OFF_CTRL) begin
        ctrl_q <= audio_clk_pkg::ctrl_t'(ctrl_w[7:0]);
      end
      if (wr && WB_ADR_I == `ACD_OFF_PDMDIV) begin
        pdiv_q <= audio_clk_pkg::pdm_div_t'(pdiv_w[23:0]);
      end
      if (wr && WB_ADR_I == `ACD_OFF_I2STX) begin
        tx_q <= tx_w;
      end
    end
  end
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = rdat_q;

  // ****************************************************************
  // three stage divider chain
  // ****************************************************************
  // legal divisors, clamped from the software image
  wire [2:0] d1_cfg = 3'(clamp5({2'h0, pdiv_q.div1},
    {2'h0, `ACD_DIV12_MIN}, {2'h0, `ACD_DIV12_MAX}));
  wire [2:0] d2_cfg = 3'(clamp5({2'h0, pdiv_q.div2},
    {2'h0, `ACD_DIV12_MIN}, {2'h0, `ACD_DIV12_MAX}));
  wire [4:0] d3_cfg = clamp5(pdiv_q.div3, `ACD_DIV3_MIN, `ACD_DIV3_MAX);
  logic [2:0] c1_q, d1_q, c2_q, d2_q; // stage counters and live divisors
  logic [4:0] c3_q, d3_q;
  logic conv_q, mast_q, mic_q; // registered clock outputs
  wire run = ctrl_q.enable;
  // while running, a stage picks up a new divisor only at the end of its period; parked, it loads at once
  wire c1_wrap = run & (c1_q == d1_q - 3'h1);
  wire c2_wrap = c1_wrap & (c2_q == d2_q - 3'h1);
  wire c3_step = c2_wrap;
  wire c3_wrap = c3_step & (c3_q == d3_q - 5'h01);
  wire [4:0] c3_nxt = c3_wrap ? 5'h00 : c3_q + 5'h01;
  wire [4:0] d3_nxt = c3_wrap ? d3_cfg : d3_q;
  // high for the first half of the period, longer half low when odd
  wire mic_d = c3_nxt < (d3_nxt >> 1);

  // divider counters
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      c1_q <= 3'h0;
      c2_q <= 3'h0;
      c3_q <= 5'h00;
      d1_q <= `ACD_DIV1_RST;
      d2_q <= `ACD_DIV2_RST;
      d3_q <= `ACD_DIV3_RST;
      conv_q <= 1'b0;
      mast_q <= 1'b0;
      mic_q <= 1'b0;
    end else begin
      conv_q <= c1_wrap;
      mast_q <= c2_wrap;
      if (!run) begin
        // parked: counters restart cleanly when enabled again
        c1_q <= 3'h0;
        c2_q <= 3'h0;
        c3_q <= 5'h00;
        d1_q <= d1_cfg;
        d2_q <= d2_cfg;
        d3_q <= d3_cfg;
        mic_q <= 1'b0;
      end else begin
        c1_q <= c1_wrap ? 3'h0 : c1_q + 3'h1;
        if (c1_wrap) begin
          d1_q <= d1_cfg;
          c2_q <= c2_wrap ? 3'h0 : c2_q + 3'h1;
        end
        if (c2_wrap) begin
          d2_q <= d2_cfg;
        end
        if (c3_step) begin
          c3_q <= c3_nxt;
          d3_q <= d3_nxt;
          mic_q <= mic_d;
        end
      end
    end
  end
  assign CONVERTER_CLOCK_TICK = conv_q;
  assign MASTER_CLOCK_TICK = mast_q;
  assign MIC_CLOCK_OUT = mic_q;

  // ****************************************************************
  // two channel pdm decimator
  // ****************************************************************
  // channel 0 is taken on the mic clock rise, channel 1 on the fall
  wire mic_rise = c3_step & mic_d & ~mic_q;
  wire mic_fall = c3_step & ~mic_d & mic_q;
  wire [7:0] dec = (pdiv_q.dec == 8'h00) ? 8'h01 : pdiv_q.dec;
  wire [8:0] win = {dec, 1'b0}; // mic periods per sample
  logic [8:0] per_q, ones0_q, ones1_q; // period and ones counters
  logic valid_q;
  // a shrunken window closes at once instead of wrapping the counter
  wire per_end = mic_rise & (per_q >= win - 9'h001);
  // boxcar result centred on zero, widened to the pcm word
  wire signed [9:0] diff0 = $signed({ones0_q, 1'b0}) - $signed({1'b0, win});
  wire signed [9:0] diff1 = $signed({ones1_q, 1'b0}) - $signed({1'b0, win});
  wire [PCM_W-1:0] pcm0_d = PCM_W'(diff0) << (PCM_W - 10);
  wire [PCM_W-1:0] pcm1_d = PCM_W'(diff1) << (PCM_W - 10);

  // accumulate bits and emit one word per channel per window
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      per_q <= 9'h000;
      ones0_q <= 9'h000;
      ones1_q <= 9'h000;
      pcm0_q <= '0;
      pcm1_q <= '0;
      valid_q <= 1'b0;
    end else begin
      valid_q <= per_end;
      if (per_end) begin
        per_q <= 9'h000;
        pcm0_q <= pcm0_d;
        pcm1_q <= pcm1_d;
        ones0_q <= {8'h00, PDM_DATA};
        ones1_q <= 9'h000;
      end else begin
        if (mic_rise) begin
          per_q <= per_q + 9'h001;
          ones0_q <= ones0_q + {8'h00, PDM_DATA};
        end
        if (mic_fall) begin
          ones1_q <= ones1_q + {8'h00, PDM_DATA};
        end
      end
    end
  end
  assign PCM_VALID = valid_q;

  // ****************************************************************
  // pll settings and codec divider selection
  // ****************************************************************
  wire [5:0] cdiv_base =
    (ctrl_q.wlen == audio_clk_pkg::WLEN_8)  ? `ACD_CDIV_W8 :
    (ctrl_q.wlen == audio_clk_pkg::WLEN_16) ? `ACD_CDIV_W16 :
    `ACD_CDIV_W32;
  wire [5:0] cdiv_sel =
    (ctrl_q.rate == audio_clk_pkg::RATE_96)  ? (cdiv_base >> 1) :
    (ctrl_q.rate == audio_clk_pkg::RATE_192) ? (cdiv_base >> 2) :
    cdiv_base;
  wire [7:0] pll_p = ctrl_q.fam48 ? `ACD_PLL_P_48 : `ACD_PLL_P_441;
  wire [7:0] pll_q = ctrl_q.fam48 ? `ACD_PLL_Q_48 : `ACD_PLL_Q_441;
  logic [7:0] pmul_q, pdiv_o_q;

  // pll settings follow the sample family
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      pmul_q <= `ACD_PLL_P_441;
      pdiv_o_q <= `ACD_PLL_Q_441;
    end else begin
      pmul_q <= pll_p;
      pdiv_o_q <= pll_q;
    end
  end
  assign PLL_MULT = pmul_q;
  assign PLL_DIV = pdiv_o_q;

  // ****************************************************************
  // i2s master
  // ****************************************************************
  logic ext_q; // last sampled external master clock
  logic [5:0] ic_q; // ticks within a half bit period
  logic [5:0] bc_q; // bit within the word
  logic bclk_q, ws_q, sdo_q;
  logic [31:0] sh_q; // msb aligned shift register
  wire ext_rise = EXT_MCLK & ~ext_q;
  wire mtick = ctrl_q.ext_mclk ? ext_rise : c2_wrap;
  wire [5:0] half = cdiv_q >> 1;
  wire h_wrap = run & mtick & (ic_q == half - 6'h01);
  wire bfall = h_wrap & bclk_q;
  wire [5:0] wl = (ctrl_q.wlen == audio_clk_pkg::WLEN_8)  ? 6'h08 :
                  (ctrl_q.wlen == audio_clk_pkg::WLEN_16) ? 6'h10 : 6'h20;
  // a shorter word length ends the running word at once, never wraps
  wire w_end = bfall & (bc_q >= wl - 6'h01);
  wire [31:0] tx_al = tx_q << (6'h20 - wl);

  // bit clock, word clock and msb first data on the falling edge
  always_ff @(posedge REF_CLK) begin
    if (RST) begin
      ext_q <= 1'b0;
      ic_q <= 6'h00;
      bc_q <= 6'h00;
      bclk_q <= 1'b0;
      ws_q <= 1'b0;
      sdo_q <= 1'b0;
      sh_q <= 32'h0;
      cdiv_q <= `ACD_CDIV_W8;
    end else begin
      ext_q <= EXT_MCLK;
      if (!run) begin
        ic_q <= 6'h00;
        bc_q <= 6'h00;
        bclk_q <= 1'b0;
        cdiv_q <= cdiv_sel;
      end else if (mtick) begin
        ic_q <= h_wrap ? 6'h00 : ic_q + 6'h01;
        if (h_wrap) begin
          bclk_q <= ~bclk_q;
        end
        // divider swaps only at a word boundary, no short bit clock
        if (w_end) begin
          cdiv_q <= cdiv_sel;
        end
      end
      if (w_end) begin
        bc_q <= 6'h00;
        ws_q <= ~ws_q;
        sh_q <= {tx_al[30:0], 1'b0};
        sdo_q <= tx_al[31];
      end else if (bfall) begin
        bc_q <= bc_q + 6'h01;
        sh_q <= {sh_q[30:0], 1'b0};
        sdo_q <= sh_q[31];
      end
    end
  end
  assign I2S_BCLK = bclk_q;
  assign I2S_WS = ws_q;
  assign I2S_SDO = sdo_q;

endmodule
`default_nettype wire

// [audio_clock_props_properties.sv]
// port-level assertions for the audio clock divider chain
`default_nettype none
module audio_clock_props (
  input wire logic REF_CLK,
  input wire logic RST,
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic [31:0] WB_DAT_O,
  input wire logic WB_ACK_O,
  input wire logic MIC_CLOCK_OUT,
  input wire logic PCM_VALID,
  input wire logic I2S_BCLK,
  input wire logic I2S_WS,
  input wire logic I2S_SDO,
  input wire logic [7:0] PLL_MULT,
  input wire logic [7:0] PLL_DIV
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************************************
  // single root clock, reset masks everything
  // ****************************************************************
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  chk_ack_latency: assert property (
    WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("bus ack late");
  chk_ack_pulse: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("bus ack longer than one cycle");
  // read data idles at zero so stale values never leak
  chk_dat_idle: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data not zero while idle");
  chk_reset_state: assert property ($fell(RST) |-> !WB_ACK_O &&
    !MIC_CLOCK_OUT && !PCM_VALID && PLL_MULT == 8'h15 &&
    PLL_DIV == 8'h10)
    else $error("outputs wrong after reset");
  chk_pll_pair: assert property (
    (PLL_MULT == 8'h15 && PLL_DIV == 8'h10) ||
    (PLL_MULT == 8'h0A && PLL_DIV == 8'h07))
    else $error("pll multiplier and divider mismatch");
  chk_pcm_pulse: assert property (PCM_VALID |=> !PCM_VALID)
    else $error("sample strobe too long");
  chk_sdo_on_fall: assert property (
    $changed(I2S_SDO) |-> $fell(I2S_BCLK))
    else $error("serial data moved off a bit clock fall");
  chk_ws_on_fall: assert property (
    $changed(I2S_WS) |-> $fell(I2S_BCLK))
    else $error("word select moved off a bit clock fall");
  cover property (PCM_VALID);
  cover property ($rose(I2S_WS));
  cover property (WB_ACK_O && WB_DAT_O != 32'h0);
endmodule
bind audio_clock_divider_chain audio_clock_props audio_clock_props_inst (
  .REF_CLK, .RST, .WB_CYC_I, .WB_STB_I, .WB_DAT_O, .WB_ACK_O,
  .MIC_CLOCK_OUT, .PCM_VALID, .I2S_BCLK, .I2S_WS, .I2S_SDO, .PLL_MULT,
  .PLL_DIV);
`default_nettype wire

// [audio_far_side_model.sv]
// behavioural microphone pair and i2s codec facing the chain
`default_nettype none
module audio_far_side_model (
  input wire logic clk,
  input wire logic mic_clk,
  input wire logic bclk,
  input wire logic ws,
  input wire logic sdo,
  output logic pdm_data,
  output logic ext_mclk,
  output logic word_valid,
  output logic [31:0] word
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0] div_q; // root cycles per master clock half
  logic bclk_q; // previous bit clock level
  logic ws_q; // previous word select level
  logic [31:0] shift_q; // last 32 bits taken, kept across word edges
  initial begin
    div_q = 2'h0;
    ext_mclk = 1'b0;
    word_valid = 1'b0;
    word = 32'h0;
    shift_q = 32'h0;
    bclk_q = 1'b0;
    ws_q = 1'b0;
  end
  // ****************************************************************
  // left mic all ones while clock low, right mic all zeros
  // ****************************************************************
  assign pdm_data = mic_clk ? 1'b0 : 1'b1;
  // codec master clock, six root cycles, runs free like a crystal
  always @(posedge clk) begin
    div_q <= (div_q == 2'h2) ? 2'h0 : div_q + 2'h1;
    if (div_q == 2'h2) ext_mclk <= ~ext_mclk;
  end
  // codec takes a bit on each rise, hands the word over on a ws edge
  always @(posedge clk) begin
    bclk_q <= bclk;
    ws_q <= ws;
    word_valid <= 1'b0;
    if (bclk && !bclk_q) shift_q <= {shift_q[30:0], sdo};
    if (ws != ws_q) begin
      word <= shift_q;
      word_valid <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// [tb_audio_clock_divider_chain.sv]
// self-checking bench for the audio clock divider chain
`default_nettype none
module tb_audio_clock_divider_chain;
  timeunit 1ns;
  timeprecision 1ps;
  logic REF_CLK, RST, WB_CYC_I, WB_STB_I, WB_WE_I, WB_ACK_O;
  logic [7:0] WB_ADR_I, PLL_MULT, PLL_DIV;
  logic [3:0] WB_SEL_I;
  logic [31:0] WB_DAT_I, WB_DAT_O, word, tx;
  logic PDM_DATA, EXT_MCLK, CONVERTER_CLOCK_TICK, MASTER_CLOCK_TICK;
  logic MIC_CLOCK_OUT, PCM_VALID, I2S_BCLK, I2S_WS, I2S_SDO, word_valid;
  logic [31:0] rd_q[$]; // expected read data, oldest first
  logic [31:0] wd_q[$]; // expected codec words
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0;
  int seed = 47;
  int d1, d2, d3, cd;
  audio_clk_pkg::pdm_div_t div;
  audio_clock_divider_chain audio_clock_divider_chain_inst (.REF_CLK, .RST,
    .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I, .WB_SEL_I, .WB_DAT_I,
    .WB_DAT_O, .WB_ACK_O, .PDM_DATA, .EXT_MCLK, .CONVERTER_CLOCK_TICK,
    .MASTER_CLOCK_TICK, .MIC_CLOCK_OUT, .PCM_VALID, .I2S_BCLK, .I2S_WS,
    .I2S_SDO, .PLL_MULT, .PLL_DIV);
  audio_far_side_model audio_far_side_model_inst (.clk(REF_CLK),
    .mic_clk(MIC_CLOCK_OUT), .bclk(I2S_BCLK), .ws(I2S_WS), .sdo(I2S_SDO),
    .pdm_data(PDM_DATA), .ext_mclk(EXT_MCLK), .word_valid, .word);
  initial begin
    REF_CLK = 1'b0;
    forever #4 REF_CLK = ~REF_CLK;
  end
  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task check(input string name, input logic [31:0] exp, seen);
    total_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // classic cycle, held until ack is seen at a rising edge
  task wb(input logic we, input logic [7:0] adr, input logic [31:0] d);
    @(posedge REF_CLK);
    WB_CYC_I <= 1'b1;
    WB_STB_I <= 1'b1;
    WB_WE_I <= we;
    WB_ADR_I <= adr;
    WB_DAT_I <= d;
    do @(posedge REF_CLK); while (WB_ACK_O !== 1'b1);
    WB_CYC_I <= 1'b0;
    WB_STB_I <= 1'b0;
  endtask
  task rd(input logic [7:0] adr, input logic [31:0] e);
    rd_q.push_back(e);
    wb(1'b0, adr, 32'h0);
  endtask
  task wait_word;
    do @(posedge REF_CLK); while (word_valid !== 1'b1);
  endtask
  // cycles between rises; the first two intervals let a change settle
  // sel 0 sample strobe, 1 bit clock, 2 converter tick, 3 master tick
  task per(input logic [1:0] sel, input int exp);
    int n;
    logic p;
    logic v;
    string nm;
    v = 1'b1;
    nm = (sel == 2'h0) ? "pcm_period" : (sel == 2'h1) ? "bclk_period" :
      (sel == 2'h2) ? "conv_period" : "mast_period";
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge REF_CLK);
        n++;
        p = v;
        v = (sel == 2'h0) ? PCM_VALID : (sel == 2'h1) ? I2S_BCLK :
          (sel == 2'h2) ? CONVERTER_CLOCK_TICK : MASTER_CLOCK_TICK;
      end while (!(v === 1'b1 && p === 1'b0));
    end
    check(nm, 32'(exp), 32'(n));
  endtask
  // monitor takes the oldest note whenever a result shows up
  always @(posedge REF_CLK) begin
    if (WB_ACK_O === 1'b1 && WB_WE_I === 1'b0 && rd_q.size() > 0)
      check("read_data", rd_q.pop_front(), WB_DAT_O);
    if (word_valid === 1'b1 && wd_q.size() > 0)
      check("i2s_word", wd_q.pop_front(), {24'h0, word[7:0]});
  end
  // hang guard, well above the twenty thousand cycles expected
  always @(posedge REF_CLK) begin
    cycles++;
    if (cycles == 60000) begin
      mismatches++;
      report_and_stop;
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    RST = 1'b1;
    WB_CYC_I = 1'b0;
    WB_STB_I = 1'b0;
    WB_WE_I = 1'b0;
    WB_ADR_I = 8'h00;
    WB_SEL_I = 4'hF;
    WB_DAT_I = 32'h0;
    repeat (4) @(posedge REF_CLK);
    RST <= 1'b0;
    div = '{dec: 8'h40, div3: 5'h02, div2: 3'h1, div1: 3'h1, default: '0};
    rd(8'h00, 32'h0);
    rd(8'h04, {8'h00, div});
    rd(8'h14, 32'h0020_1015);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0);
    $display("test reset image done");
    wb(1'b1, 8'h00, 32'h04);
    rd(8'h14, 32'h0020_070A);
    check("pll_pair", 32'h070A, {16'h0, PLL_DIV, PLL_MULT});
    wb(1'b1, 8'h00, 32'h00);
    rd(8'h14, 32'h0020_1015);
    check("pll_pair", 32'h1015, {16'h0, PLL_DIV, PLL_MULT});
    $display("test pll families done");
    for (int r = 0; r < 3; r++) begin
      for (int w = 0; w < 3; w++) begin
        cd = 32 >> (r + w);
        wb(1'b1, 8'h00, {24'h0, 2'(w), 2'(r), 4'h1});
        wait_word;
        wait_word;
        rd(8'h14, {10'h0, 6'(cd), 16'h1015});
        per(2'h1, cd);
      end
    end
    $display("test codec dividers done");
    tx = $random(seed);
    wb(1'b1, 8'h00, 32'h01);
    wb(1'b1, 8'h10, tx);
    // the first words may still carry what was loaded before the write
    wait_word;
    wait_word;
    wait_word;
    wd_q.push_back({24'h0, tx[7:0]});
    wait_word;
    $display("test i2s word done");
    // at least two, so the converter tick has edges to time
    d1 = 2 + {$random(seed)} % 3;
    d2 = 1 + {$random(seed)} % 4;
    d3 = 2 + {$random(seed)} % 15;
    div = '{dec: 8'h04, div3: 5'(d3), div2: 3'(d2), div1: 3'(d1),
      default: '0};
    wb(1'b1, 8'h04, {8'h00, div});
    per(2'h0, 8 * d1 * d2 * d3);
    rd(8'h08, 32'h0002_0000);
    rd(8'h0C, 32'hFFFE_0000);
    per(2'h2, d1);
    per(2'h3, d1 * d2);
    $display("test microphone chain done");
    wb(1'b1, 8'h00, 32'h03);
    // model edge every 6 root cycles, 32 ticks per bit clock period
    per(2'h1, 6 * 32);
    per(2'h0, 8 * d1 * d2 * d3);
    $display("test external master clock done");
    repeat (2) @(posedge REF_CLK);
    report_and_stop;
  end
endmodule
`default_nettype wire
